// ---- hdl/odt_cfg.svh ----
// Constants for the termination mode transition block: timing figures, counts and
// command codes. Included by the transition block, the controller model and the bench; holds definitions only.
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH

// Link (command) clock period assumed for turning nanosecond figures into cycles.
`define CK_PERIOD_NS            64
// Asynchronous turn-on and turn-off least delays, in ns.
`define ASYNC_ON_MIN_NS         2
`define ASYNC_OFF_MIN_NS        2
// Least delays in link cycles, rounded up, never below one cycle.
`define ASYNC_ON_MIN_CYC  (((`ASYNC_ON_MIN_NS + `CK_PERIOD_NS - 1) / `CK_PERIOD_NS) > 0 ? \
  ((`ASYNC_ON_MIN_NS + `CK_PERIOD_NS - 1) / `CK_PERIOD_NS) : 1)
`define ASYNC_OFF_MIN_CYC (((`ASYNC_OFF_MIN_NS + `CK_PERIOD_NS - 1) / `CK_PERIOD_NS) > 0 ? \
  ((`ASYNC_OFF_MIN_NS + `CK_PERIOD_NS - 1) / `CK_PERIOD_NS) : 1)
// Synchronous latency is write latency minus this offset.
`define TERM_LAT_OFFSET         2
// Power-down lead interval is write latency minus this offset.
`define PD_LEAD_OFFSET          1
// Minimum high time of the termination control pin, in cycles.
`define TERM_MIN_HIGH_CYC       4
// Post-entry minimum delay, exit DLL delay and refresh cycle minimum, in cycles.
`define PD_ENTRY_DELAY_MIN_CYC  1
`define PD_EXIT_DLL_DELAY_CYC   10
`define REFRESH_CYCLE_MIN_CYC   8
// Write latency used until configured otherwise.
`define WRITE_LATENCY_RESET     5'h05
// Command codes on {cs_n, ras_n, cas_n, we_n}.
`define CMD_REFRESH             4'h1
`define CMD_WRITE               4'h4
`define CMD_READ                4'h5

`endif

// ---- hdl/odt_pkg.sv ----
// Types shared by the termination mode transition modules.
// Assumes odt_cfg.svh supplies the numeric constants.
package odt_pkg;

  typedef enum logic [1:0] {
    PWR_UP = 2'h1,
    PWR_DN = 2'h2
  } pd_state_type;

  typedef struct packed {
    logic         pin_q;
    logic         pin_p;
    logic         cke_q;
    logic         cke_p;
    logic [3:0]   cmd_q;
    logic         frz_s1;
    logic         frz_s2;
    logic [4:0]   wl_s1;
    logic [4:0]   wl_s2;
    pd_state_type pd_q;
    logic [7:0]   entry_cnt_q;
    logic [7:0]   exit_cnt_q;
    logic [7:0]   rfc_cnt_q;
    logic [5:0]   age_q;
    logic         uncertain_q;
    logic         rtt_on_q;
    logic         cmd_err_q;
    logic [2:0]   high_cnt_q;
    logic         high_short_q;
    logic         async_q;
    logic         win_q;
  } ck_state_type;

  typedef struct packed {
    logic [1:0] async_s;
    logic [1:0] unc_s;
    logic [1:0] win_s;
    logic [1:0] err_s;
    logic [1:0] short_s;
  } sys_state_type;

endpackage

// ---- hdl/term_delay_if.sv ----
// Carrier between the transition block and its pin history delay lines.
// The user side feeds one sample per link cycle and picks a tap.
`timescale 1ns/100ps
interface term_delay_if #(
  parameter int unsigned DEPTH = 32
);
  logic                     din;
  logic [$clog2(DEPTH)-1:0] tap;
  logic                     dout;

  modport line (input din, input tap, output dout);
  modport user (output din, output tap, input dout);
endinterface

// ---- hdl/term_delay_line.sv ----
// Shift register of termination pin samples with a selectable tap.
// Assumes one sample per clock; tap 0 gives the sample one cycle late.
`timescale 1ns/100ps
module term_delay_line #(
  parameter int unsigned DEPTH = 32
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  term_delay_if.line      port_if
);
  typedef struct packed {
    logic [DEPTH-1:0] hist;
  } line_state_type;

  line_state_type q;
  line_state_type d;

  always_comb begin
    d      = q;
    d.hist = {q.hist[DEPTH-2:0], port_if.din};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign port_if.dout = q.hist[port_if.tap];
endmodule // term_delay_line

// ---- hdl/odt_async_mode_transition.sv ----
// Termination response of the memory device around precharge power-down with the
// DLL frozen: synchronous or asynchronous timing and the transition windows.
// Assumes command pins are synchronous to ck_i and that power-down is entered only
// from the precharged state; configuration inputs are quasi-static.
//
// Behaviour
// - Frozen-DLL precharge power-down uses asynchronous termination timing.
// - Mode register zero bit A12 at 0 freezes DLL and enables windows.
// - Asynchronous termination request is not delayed by added latency.
// - Asynchronous turn-on measured from pin sampled high, least two.
// - Asynchronous turn-off measured from pin sampled low, least two.
// - Pin receiver stays active in power-down; no reads or writes allowed.
// - Entry lead is write latency minus one before clock enable registered low.
// - Entry window excludes lead start, includes post-entry delay end.
// - Refresh in progress stretches entry window to later refresh end.
// - Change inside window lies between smaller minimum and larger maximum.
// - Exit window runs lead before to exit DLL delay after clock enable high.
// - Short power-down: either response from entry start to exit end.
// - Short idle: either response from exit start through next entry window.
// - Synchronous turn-on latency is write latency minus two cycles.
`timescale 1ns/100ps
`include "odt_cfg.svh"
module odt_async_mode_transition #(
  parameter int unsigned DEPTH           = 32,
  parameter logic [7:0]  ENTRY_DELAY_CYC = 8'(`PD_ENTRY_DELAY_MIN_CYC),
  parameter logic [7:0]  EXIT_DLL_CYC    = 8'(`PD_EXIT_DLL_DELAY_CYC),
  parameter logic [7:0]  REFRESH_CYC     = 8'(`REFRESH_CYCLE_MIN_CYC)
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       mode_reg_zero_a12_i,
  input  wire logic [4:0] write_latency_total_i,
  input  wire logic       ck_i,
  input  wire logic       cke_i,
  input  wire logic       cs_n_i,
  input  wire logic       ras_n_i,
  input  wire logic       cas_n_i,
  input  wire logic       we_n_i,
  input  wire logic       termination_control_pin_i,
  output logic            rtt_on_o,
  output logic            async_mode_o,
  output logic            term_uncertain_o,
  output logic            window_open_o,
  output logic            pd_cmd_err_o,
  output logic            term_high_short_o
);
  localparam int unsigned TAPW = $clog2(DEPTH);
  localparam logic [5:0]  AGE_MAX = 6'h3f;

  // Clock enable and the freeze input start at their idle levels so the edge
  // detectors see no false entry or exit right after reset.
  localparam odt_pkg::ck_state_type CK_RESET = '{
    cke_q:  1'b1,
    cke_p:  1'b1,
    cmd_q:  4'hf,
    frz_s1: 1'b1,
    frz_s2: 1'b1,
    wl_s1:  `WRITE_LATENCY_RESET,
    wl_s2:  `WRITE_LATENCY_RESET,
    pd_q:   odt_pkg::PWR_UP,
    age_q:  6'h3f,
    default: '0
  };

  // Reset is released separately in each domain so neither sees a torn release.
  logic [1:0] sys_rst_q;
  logic [1:0] ck_rst_q;
  logic       sys_rst_n;
  logic       ck_rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sys_rst_q <= 2'h0;
    end else begin
      sys_rst_q <= {sys_rst_q[0], 1'b1};
    end
  end

  always_ff @(posedge ck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ck_rst_q <= 2'h0;
    end else begin
      ck_rst_q <= {ck_rst_q[0], 1'b1};
    end
  end

  assign sys_rst_n = sys_rst_q[1];
  assign ck_rst_n  = ck_rst_q[1];

  odt_pkg::ck_state_type  cq;
  odt_pkg::ck_state_type  cd;
  odt_pkg::sys_state_type sq;
  odt_pkg::sys_state_type sd;

  term_delay_if #(.DEPTH(DEPTH)) sync_if ();
  term_delay_if #(.DEPTH(DEPTH)) async_if ();

  term_delay_line #(.DEPTH(DEPTH)) sync_line (
    .clk_i   (ck_i),
    .rst_n_i (ck_rst_n),
    .port_if (sync_if)
  );

  term_delay_line #(.DEPTH(DEPTH)) async_line (
    .clk_i   (ck_i),
    .rst_n_i (ck_rst_n),
    .port_if (async_if)
  );

  // Link-domain decode.
  logic       pin_chg;
  logic       cke_fall;
  logic       cke_rise;
  logic       frozen;
  logic       win_open;
  logic [5:0] lead;
  logic       lead_hit;
  logic [7:0] entry_len;
  logic [4:0] sync_tap;
  logic [4:0] async_tap;
  logic       rtt_next;
  logic       is_rw;

  // The line output lands two edges after the sample is registered, so the tap
  // sits two below the wanted latency; latencies below two are shown as two.
  always_comb begin
    sync_tap = 5'h00;
    if (cq.wl_s2 > 5'(`TERM_LAT_OFFSET + 2)) begin
      sync_tap = cq.wl_s2 - 5'(`TERM_LAT_OFFSET + 2);
    end
    async_tap = 5'h00;
    if (`ASYNC_ON_MIN_CYC > 2) begin
      async_tap = 5'(`ASYNC_ON_MIN_CYC - 2);
    end
  end

  assign sync_if.din  = cq.pin_q;
  assign sync_if.tap  = TAPW'(sync_tap);
  assign async_if.din = cq.pin_q;
  assign async_if.tap = TAPW'(async_tap);

  assign pin_chg  = cq.pin_q != cq.pin_p;
  assign cke_fall = cq.cke_p && !cq.cke_q;
  assign cke_rise = !cq.cke_p && cq.cke_q;
  assign frozen   = !cq.frz_s2;
  assign win_open = (cq.entry_cnt_q != 8'h00) || (cq.exit_cnt_q != 8'h00);
  assign is_rw    = (cq.cmd_q == `CMD_READ) || (cq.cmd_q == `CMD_WRITE);

  // A change counts toward a registration when it lies strictly after the lead
  // start; the start itself is outside the window.
  always_comb begin
    lead = 6'h00;
    if (cq.wl_s2 > 5'(`PD_LEAD_OFFSET)) begin
      lead = 6'(cq.wl_s2 - 5'(`PD_LEAD_OFFSET));
    end
    lead_hit = cq.age_q < lead;
  end

  always_comb begin
    entry_len = ENTRY_DELAY_CYC;
    if (cq.rfc_cnt_q > ENTRY_DELAY_CYC) begin
      entry_len = cq.rfc_cnt_q;
    end
  end

  always_comb begin
    cd        = cq;
    cd.pin_q  = termination_control_pin_i;
    cd.pin_p  = cq.pin_q;
    cd.cke_q  = cke_i;
    cd.cke_p  = cq.cke_q;
    cd.cmd_q  = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    cd.frz_s1 = mode_reg_zero_a12_i;
    cd.frz_s2 = cq.frz_s1;
    cd.wl_s1  = write_latency_total_i;
    cd.wl_s2  = cq.wl_s1;

    if (pin_chg) begin
      cd.age_q = 6'h00;
    end else if (cq.age_q != AGE_MAX) begin
      cd.age_q = cq.age_q + 6'h01;
    end

    if (cq.cmd_q == `CMD_REFRESH && cq.cke_q && cq.cke_p) begin
      cd.rfc_cnt_q = REFRESH_CYC;
    end else if (cq.rfc_cnt_q != 8'h00) begin
      cd.rfc_cnt_q = cq.rfc_cnt_q - 8'h01;
    end

    if (cq.entry_cnt_q != 8'h00) begin
      cd.entry_cnt_q = cq.entry_cnt_q - 8'h01;
    end
    if (cq.exit_cnt_q != 8'h00) begin
      cd.exit_cnt_q = cq.exit_cnt_q - 8'h01;
    end

    // Windows are kept as two counters and flagged on their union, so overlap of
    // an entry and an exit window in either order leaves no gap.
    unique case (cq.pd_q)
      odt_pkg::PWR_UP: begin
        if (cke_fall) begin
          cd.pd_q = odt_pkg::PWR_DN;
          if (frozen) begin
            cd.entry_cnt_q = entry_len;
            if (lead_hit && cq.age_q != AGE_MAX) begin
              cd.uncertain_q = 1'b1;
            end
          end
        end
      end
      odt_pkg::PWR_DN: begin
        if (is_rw) begin
          cd.cmd_err_q = 1'b1;
        end
        if (cke_rise) begin
          cd.pd_q = odt_pkg::PWR_UP;
          if (frozen) begin
            cd.exit_cnt_q = EXIT_DLL_CYC;
            if (lead_hit && cq.age_q != AGE_MAX) begin
              cd.uncertain_q = 1'b1;
            end
          end
        end
      end
    endcase

    if (pin_chg && win_open) begin
      cd.uncertain_q = 1'b1;
    end else if (!win_open && (sync_if.dout == async_if.dout)) begin
      cd.uncertain_q = 1'b0;
    end

    // Inside an uncertain span the pin is followed on the asynchronous path, whose
    // change is the earliest of the two legal ones and never later than the latest.
    if (cq.uncertain_q) begin
      rtt_next = async_if.dout;
    end else if (cq.pd_q == odt_pkg::PWR_DN && frozen && !win_open) begin
      rtt_next = async_if.dout;
    end else begin
      rtt_next = sync_if.dout;
    end
    cd.rtt_on_q = rtt_next;

    if (cq.pin_q) begin
      if (cq.high_cnt_q != 3'h7) begin
        cd.high_cnt_q = cq.high_cnt_q + 3'h1;
      end
    end else begin
      cd.high_cnt_q = 3'h0;
    end
    if (pin_chg && !cq.pin_q && cq.high_cnt_q < 3'(`TERM_MIN_HIGH_CYC)) begin
      cd.high_short_q = 1'b1;
    end

    // Mode and window are registered here so that each crosses as one clean level.
    cd.async_q = (cq.pd_q == odt_pkg::PWR_DN) && frozen && !win_open;
    cd.win_q   = win_open;
  end

  always_ff @(posedge ck_i or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      cq <= CK_RESET;
    end else begin
      cq <= cd;
    end
  end

  // Status levels cross into the system clock through two flip-flops each; every
  // one is a slow level or a sticky flag, so no word crosses as a whole.
  always_comb begin
    sd         = sq;
    sd.async_s = {sq.async_s[0], cq.async_q};
    sd.unc_s   = {sq.unc_s[0], cq.uncertain_q};
    sd.win_s   = {sq.win_s[0], cq.win_q};
    sd.err_s   = {sq.err_s[0], cq.cmd_err_q};
    sd.short_s = {sq.short_s[0], cq.high_short_q};
  end

  always_ff @(posedge clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  // Termination follows the link clock directly; moving it to the system clock
  // would blur the latency that it must keep.
  assign rtt_on_o          = cq.rtt_on_q;
  assign async_mode_o      = sq.async_s[1];
  assign term_uncertain_o  = sq.unc_s[1];
  assign window_open_o     = sq.win_s[1];
  assign pd_cmd_err_o      = sq.err_s[1];
  assign term_high_short_o = sq.short_s[1];
endmodule // odt_async_mode_transition

// ---- bench/odt_async_mode_transition_props.sv ----
// Concurrent checks on the ports of the termination transition block.
// Assumes ck_i is the link clock; outputs may lag it by a few system clocks.
`timescale 1ns/100ps
module odt_async_mode_transition_props (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       mode_reg_zero_a12_i,
  input wire logic [4:0] write_latency_total_i,
  input wire logic       ck_i,
  input wire logic       cke_i,
  input wire logic       cs_n_i,
  input wire logic       ras_n_i,
  input wire logic       cas_n_i,
  input wire logic       we_n_i,
  input wire logic       termination_control_pin_i,
  input wire logic       rtt_on_o,
  input wire logic       async_mode_o,
  input wire logic       term_uncertain_o,
  input wire logic       window_open_o,
  input wire logic       pd_cmd_err_o,
  input wire logic       term_high_short_o
);
  logic [5:0] hi_q;
  logic [5:0] lo_q;
  // Saturating run lengths of clock enable, so windows are long over before we judge.
  always_ff @(posedge ck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_q <= 6'h00;
      lo_q <= 6'h00;
    end else begin
      hi_q <= cke_i ? hi_q + 6'(hi_q != 6'h3f) : 6'h00;
      lo_q <= cke_i ? 6'h00 : lo_q + 6'(lo_q != 6'h3f);
    end
  end
  default clocking cb @(posedge ck_i); endclocking
  default disable iff (!arst_n_i);
  a_async_leaves: assert property (cke_i && hi_q == 6'h3f |-> !async_mode_o)
    else $error("async mode held after long power-up");
  a_async_in_pd: assert property (!cke_i && lo_q == 6'h10 && !mode_reg_zero_a12_i
    |-> async_mode_o)
    else $error("async mode missing in frozen power-down");
  a_no_freeze_a12: assert property (mode_reg_zero_a12_i |-> !window_open_o && !async_mode_o)
    else $error("window or async mode with DLL kept running");
  a_window_shut: assert property (cke_i && hi_q == 6'h3f |-> !window_open_o)
    else $error("window open long after exit");
  a_entry_window: assert property ($fell(cke_i) && hi_q == 6'h3f && !mode_reg_zero_a12_i
    |-> ##[1:3] window_open_o)
    else $error("entry window not opened");
  a_exit_window: assert property ($rose(cke_i) && lo_q == 6'h3f && !mode_reg_zero_a12_i
    |-> ##[1:3] window_open_o)
    else $error("exit window not opened");
  a_sync_on: assert property (cke_i && hi_q == 6'h3f && write_latency_total_i == 5'h0c
    && $rose(termination_control_pin_i) && !rtt_on_o
    |=> !rtt_on_o [*7] ##[1:8] rtt_on_o)
    else $error("synchronous turn-on latency wrong");
  a_async_on: assert property (!cke_i && lo_q == 6'h3f && !mode_reg_zero_a12_i
    && $rose(termination_control_pin_i) |-> ##[1:4] rtt_on_o)
    else $error("asynchronous turn-on late");
  a_async_off: assert property (!cke_i && lo_q == 6'h3f && !mode_reg_zero_a12_i
    && $fell(termination_control_pin_i) |-> ##[1:4] !rtt_on_o)
    else $error("asynchronous turn-off late");
  c_entry: cover property ($fell(cke_i) && !mode_reg_zero_a12_i);
  c_err: cover property ($rose(pd_cmd_err_o));
  c_short: cover property ($rose(term_high_short_o));
endmodule // odt_async_mode_transition_props
bind odt_async_mode_transition odt_async_mode_transition_props i_props (.*);

// ---- bench/mem_ctrl_model.sv ----
// Memory controller model: clock enable, commands and the termination pin.
// Assumes the device samples on the rising edge of ck_i; all changes land on falling edges.
`timescale 1ns/100ps
`include "odt_cfg.svh"
module mem_ctrl_model (
  input  wire logic ck_i,
  output logic       cke_o,
  output logic [3:0] cmd_o,
  output logic       pin_o
);
  logic [2:0] high_n;
  initial begin
    cke_o = 1'b1;
    cmd_o = 4'h7;
    pin_o = 1'b0;
    high_n = 3'h0;
  end
  always @(posedge ck_i) high_n <= pin_o ? high_n + 3'(high_n != 3'h7) : 3'h0;
  // Called at a falling edge; bad lets a scenario break the controller's duties.
  task automatic drive(input logic cke, input logic [3:0] cmd, input logic pin,
                       input logic bad, input int n);
    while (!pin && pin_o && !bad && high_n < 3'h4) @(negedge ck_i);
    cke_o = cke;
    pin_o = pin;
    cmd_o = (!cke && !bad && (cmd == `CMD_WRITE || cmd == `CMD_READ)) ? 4'h7 : cmd;
    @(negedge ck_i);
    cmd_o = 4'h7;
    repeat (n - 1) @(negedge ck_i);
  endtask
endmodule // mem_ctrl_model

// ---- bench/odt_async_mode_transition_tb.sv ----
// Self-checking bench for the termination transition block.
// Assumes write latency twelve, so synchronous turn-on needs ten link cycles.
`timescale 1ns/100ps
`include "odt_cfg.svh"
module odt_async_mode_transition_tb;
  localparam logic [3:0] NOP = 4'h7;
  // Rows: {a12, cke, pin, expected async mode, expected termination}.
  localparam logic [4:0] ROWS [5] = '{5'h07, 5'h02, 5'h08, 5'h15, 5'h18};
  logic       clk;
  logic       ck;
  logic       arst_n;
  logic       a12;
  logic       cke;
  logic [3:0] cmd;
  logic       pin;
  logic       rtt;
  logic       asy;
  logic       unc;
  logic       win;
  logic       err;
  logic       shrt;
  int         checked;
  int         n_mismatch;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #3;
    forever #32 ck = ~ck;
  end
  mem_ctrl_model i_mem_ctrl_model (.ck_i(ck), .cke_o(cke), .cmd_o(cmd), .pin_o(pin));
  odt_async_mode_transition i_odt_async_mode_transition (
    .clk_i(clk), .arst_n_i(arst_n), .mode_reg_zero_a12_i(a12),
    .write_latency_total_i(5'h0c), .ck_i(ck), .cke_i(cke), .cs_n_i(cmd[3]),
    .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
    .termination_control_pin_i(pin), .rtt_on_o(rtt), .async_mode_o(asy),
    .term_uncertain_o(unc), .window_open_o(win), .pd_cmd_err_o(err),
    .term_high_short_o(shrt));
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Flags may be pulses or levels, so poll for a bounded time.
  task automatic wait_set(ref logic s);
    int k;
    for (k = 0; k < 50 && s !== 1'b1; k++) @(posedge clk);
    check(5'(s), 5'h01);
    if (k == 50) give_verdict();
  endtask
  initial begin
    arst_n = 1'b0;
    a12 = 1'b0;
    checked = 0;
    n_mismatch = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ck);
    check(5'({rtt, asy, win, err, shrt}), 5'h00);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      a12 = ROWS[i][4];
      repeat (4) @(negedge ck);
      i_mem_ctrl_model.drive(ROWS[i][3], NOP, ROWS[i][2], 1'b0, 70);
      check(5'({asy, rtt}), 5'(ROWS[i][1:0]));
    end
    $display("table test done");
    a12 = 1'b0;
    i_mem_ctrl_model.drive(1'b1, NOP, 1'b1, 1'b0, 6);
    check(5'(rtt), 5'h00);
    i_mem_ctrl_model.drive(1'b1, NOP, 1'b1, 1'b0, 12);
    check(5'(rtt), 5'h01);
    i_mem_ctrl_model.drive(1'b0, NOP, 1'b0, 1'b0, 70);
    i_mem_ctrl_model.drive(1'b0, NOP, 1'b1, 1'b0, 3);
    check(5'(rtt), 5'h01);
    $display("latency test done");
    // A three-cycle pulse breaks the minimum high time on purpose.
    i_mem_ctrl_model.drive(1'b0, NOP, 1'b0, 1'b1, 3);
    check(5'(rtt), 5'h00);
    wait_set(shrt);
    i_mem_ctrl_model.drive(1'b0, `CMD_WRITE, 1'b0, 1'b1, 3);
    wait_set(err);
    $display("fault test done");
    i_mem_ctrl_model.drive(1'b1, NOP, 1'b0, 1'b0, 4);
    check(5'(win), 5'h01);
    i_mem_ctrl_model.drive(1'b1, NOP, 1'b1, 1'b0, 4);
    wait_set(unc);
    i_mem_ctrl_model.drive(1'b1, NOP, 1'b0, 1'b0, 70);
    check(5'(win), 5'h00);
    $display("exit test done");
    give_verdict();
  end
endmodule // odt_async_mode_transition_tb
